// >>> gho_pkg.sv
// Purpose: Shared constants and types for the gate and hold-off control.
// Assumes: 125 MHz timebase clock, classic Wishbone with 32-bit data.
// Notes: All register offsets are byte addresses of aligned words.
package gho_pkg;
   localparam int DW = 32;
   localparam int AW = 8;
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_HOLDOFF = 8'h04;
   localparam logic [7:0] ADR_MEASTIME = 8'h08;
   localparam logic [7:0] ADR_STATUS = 8'h0C;
   localparam logic [7:0] ADR_EVENTS = 8'h10;
   localparam logic [7:0] ADR_TICKS = 8'h14;
   // Control register fields.
   localparam int FN_LSB = 0;
   localparam int XM_LSB = 4;
   localparam int SLOPE_BIT = 6;
   localparam int HO_BIT = 7;
   localparam int TID_BIT = 8;
   localparam int SINGLE_BIT = 9;
   localparam int RUN_BIT = 10;
   localparam int HIRES_BIT = 11;
   // Status register fields.
   localparam int ST_GATE_BIT = 0;
   localparam int ST_HOBLK_BIT = 1;
   localparam int ST_TID_BIT = 2;
   localparam int ST_RECIP_BIT = 3;
   localparam int ST_XREJ_BIT = 4;
   localparam int ST_XM_LSB = 5;
   localparam int ST_STATE_LSB = 8;
   // Measurement functions.
   localparam logic [2:0] FN_FREQ = 3'h0;
   localparam logic [2:0] FN_PERIOD = 3'h1;
   localparam logic [2:0] FN_RATIO = 3'h2;
   localparam logic [2:0] FN_TOTAL = 3'h3;
   localparam logic [2:0] FN_INTERVAL = 3'h4;
   localparam logic [2:0] FN_WIDTH = 3'h5;
   localparam logic [2:0] FN_EDGE = 3'h6;
   // External control modes.
   localparam logic [1:0] XM_OFF = 2'h0;
   localparam logic [1:0] XM_ARM = 2'h1;
   localparam logic [1:0] XM_GATE = 2'h2;
   localparam logic [1:0] XM_AVG = 2'h3;
   // Timing.
   localparam int CLK_MHZ = 125;
   localparam int MEAS_TIME_US = 1000;
   localparam int MEAS_CYC = MEAS_TIME_US * CLK_MHZ;
   // Reset values.
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] HOLDOFF_RST = 32'h0000_0000;
   localparam logic [31:0] MEASTIME_RST = 32'(MEAS_CYC);
   localparam logic [31:0] ZERO_W = 32'h0000_0000;

   typedef enum logic [4:0] {
      ST_IDLE = 5'b0_0001,
      ST_ARM_WAIT = 5'b0_0010,
      ST_START_WAIT = 5'b0_0100,
      ST_GATE = 5'b0_1000,
      ST_STOP_WAIT = 5'b1_0000
   } gho_state_t;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [AW-1:0] adr;
      logic [DW-1:0] dat;
   } gho_wb_req_t;
endpackage : gho_pkg

// >>> gho_gate_ctrl.sv
// Purpose: Measurement gate control with trigger hold-off and delay.
// Assumes: Trigger inputs are one-cycle pulses synchronous to clk_i.
// Notes: Registers are reached over a classic Wishbone slave.
// Contract
// - Averaging on low-res model forces reciprocal measurement.
// - External reset acts like panel reset but keeps local settings.
// - Measurement stays reset while external reset is held high.
// - New measurement starts only after external reset returns low.
// - Hold-off in time modes ignores stop triggers until it expires.
// - Frequency, period: hold-off filters triggers, restarts on each accept.
// - Hold-off also applies in ratio and totalize modes.
// - Interval delay rejects stop pulses for the measuring time after start.
// - Interval delay only for single interval, width and edge time.
// - Interval delay never with hold-off; only selectable over the bus.
// - Gate monitor stays high for the whole gate including sync time.
// - Arming holds start while control is active, starts once it drops.
// - External gate starts and stops on first trigger after edges.
// - Control input polarity is selectable normal or inverted.
// - Averaging accumulates only during sample pulses in measuring time; the sync time after it counts every clock.
`timescale 1ns/1ps
module gho_gate_ctrl
   import gho_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire gho_wb_req_t wb_i,
   output logic [DW-1:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic trig_a_i,
   input wire logic trig_b_i,
   input wire logic rear_control_i,
   input wire logic ext_reset_i,
   output logic gate_open_o,
   output logic reciprocal_o
);

   function automatic logic is_time_fn(input logic [2:0] f);
      is_time_fn = (f == FN_INTERVAL) || (f == FN_WIDTH) || (f == FN_EDGE);
   endfunction : is_time_fn

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      merge = r;
   endfunction : merge

   logic [31:0] ctrl_reg, ctrl_next;
   logic [31:0] holdoff_reg, holdoff_next;
   logic [31:0] meas_reg, meas_next;
   logic [DW-1:0] dat_reg, dat_next;
   logic ack_reg, ack_next;
   gho_state_t state_reg, state_next;
   logic [31:0] tmr_reg, tmr_next;
   logic [31:0] ho_cnt_reg, ho_cnt_next;
   logic [31:0] ev_reg, ev_next;
   logic [31:0] ticks_reg, ticks_next;
   logic gate_reg, gate_next;
   logic recip_reg, recip_next;

   logic [2:0] fn;
   logic [1:0] xm_sel, xm_eff;
   logic xm_ok, ctl_act, ho_en, ho_block, tid_eff, tid_block;
   logic time_fn, sample_ok, meas_end, start_ok, req;
   logic [31:0] status_w;

   // Mode qualification shared by the bus and the measurement logic.
   always_comb begin
      fn = ctrl_reg[FN_LSB +: 3];
      xm_sel = ctrl_reg[XM_LSB +: 2];
      ctl_act = rear_control_i ^ ctrl_reg[SLOPE_BIT];
      time_fn = is_time_fn(fn);
      case (xm_sel)
         XM_ARM: xm_ok = (fn != FN_TOTAL);
         XM_GATE: xm_ok = (fn == FN_FREQ) || (fn == FN_PERIOD);
         XM_AVG: xm_ok = (fn == FN_FREQ);
         default: xm_ok = 1'b1;
      endcase
      xm_eff = xm_ok ? xm_sel : XM_OFF;
      ho_en = ctrl_reg[HO_BIT];
      ho_block = ho_en && (ho_cnt_reg < holdoff_reg);
      // Delay only for single-shot time modes, and never with hold-off.
      tid_eff = ctrl_reg[TID_BIT] && !ho_en && ctrl_reg[SINGLE_BIT]
                && time_fn;
      tid_block = tid_eff && (tmr_reg < meas_reg);
      sample_ok = (xm_eff != XM_AVG) || ctl_act;
      meas_end = (xm_eff == XM_GATE) ? !ctl_act
                 : (tmr_reg >= meas_reg);
      start_ok = trig_a_i && ((xm_eff != XM_GATE) || ctl_act);
      status_w = ZERO_W;
      status_w[ST_GATE_BIT] = gate_reg;
      status_w[ST_HOBLK_BIT] = ho_block;
      status_w[ST_TID_BIT] = tid_eff;
      status_w[ST_RECIP_BIT] = recip_reg;
      status_w[ST_XREJ_BIT] = !xm_ok;
      status_w[ST_XM_LSB +: 2] = xm_eff;
      status_w[ST_STATE_LSB +: 5] = state_reg;
   end

   // Wishbone slave: answers every request one cycle after it is seen.
   always_comb begin
      req = wb_i.cyc && wb_i.stb && !ack_reg;
      ack_next = req;
      dat_next = dat_reg;
      ctrl_next = ctrl_reg;
      holdoff_next = holdoff_reg;
      meas_next = meas_reg;
      if (req && wb_i.we) begin
         // Interval delay can only be chosen here, from the bus.
         case (wb_i.adr)
            ADR_CTRL: ctrl_next = merge(ctrl_reg, wb_i.dat, wb_i.sel);
            ADR_HOLDOFF: holdoff_next = merge(holdoff_reg, wb_i.dat, wb_i.sel);
            ADR_MEASTIME: meas_next = merge(meas_reg, wb_i.dat, wb_i.sel);
            default: ;
         endcase
      end
      if (req && !wb_i.we) begin
         case (wb_i.adr)
            ADR_CTRL: dat_next = ctrl_reg;
            ADR_HOLDOFF: dat_next = holdoff_reg;
            ADR_MEASTIME: dat_next = meas_reg;
            ADR_STATUS: dat_next = status_w;
            ADR_EVENTS: dat_next = ev_reg;
            ADR_TICKS: dat_next = ticks_reg;
            default: dat_next = ZERO_W;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_reg <= CTRL_RST;
         holdoff_reg <= HOLDOFF_RST;
         meas_reg <= MEASTIME_RST;
         dat_reg <= ZERO_W;
         ack_reg <= 1'b0;
      end else if (ce_i) begin
         ctrl_reg <= ctrl_next;
         holdoff_reg <= holdoff_next;
         meas_reg <= meas_next;
         dat_reg <= dat_next;
         ack_reg <= ack_next;
      end
   end

   // Measurement sequencer.
   always_comb begin
      state_next = state_reg;
      tmr_next = tmr_reg;
      ev_next = ev_reg;
      ticks_next = ticks_reg;
      ho_cnt_next = ho_cnt_reg;
      if ((state_reg == ST_GATE || state_reg == ST_STOP_WAIT)
          && ho_block) begin
         ho_cnt_next = ho_cnt_reg + 32'h0000_0001;
      end
      case (state_reg)
         ST_IDLE: begin
            if (ctrl_reg[RUN_BIT]) begin
               state_next = (xm_eff == XM_ARM) ? ST_ARM_WAIT
                            : ST_START_WAIT;
            end
         end
         ST_ARM_WAIT: begin
            if (!ctl_act) begin
               state_next = ST_START_WAIT;
            end
         end
         ST_START_WAIT: begin
            if (start_ok) begin
               state_next = ST_GATE;
               tmr_next = ZERO_W;
               ev_next = ZERO_W;
               ticks_next = ZERO_W;
               ho_cnt_next = ZERO_W;
            end
         end
         ST_GATE: begin
            tmr_next = tmr_reg + 32'h0000_0001;
            if (sample_ok) begin
               ticks_next = ticks_reg + 32'h0000_0001;
            end
            if (time_fn) begin
               if (trig_b_i && !ho_block && !tid_block) begin
                  state_next = ST_IDLE;
               end
            end else begin
               // Noise filter: each accepted edge restarts hold-off.
               if (trig_a_i && !ho_block && sample_ok) begin
                  ev_next = ev_reg + 32'h0000_0001;
                  ho_cnt_next = ZERO_W;
               end
               if (meas_end) begin
                  state_next = ST_STOP_WAIT;
               end
            end
         end
         ST_STOP_WAIT: begin
            // The gate stays open until the input resynchronises.
            ticks_next = ticks_reg + 32'h0000_0001;
            if (trig_a_i && !ho_block) begin
               ev_next = ev_reg + 32'h0000_0001;
               state_next = ST_IDLE;
            end
         end
         default: state_next = ST_IDLE;
      endcase
      // Settings survive; only the measurement is cleared and held.
      if (ext_reset_i) begin
         state_next = ST_IDLE;
         tmr_next = ZERO_W;
         ev_next = ZERO_W;
         ticks_next = ZERO_W;
         ho_cnt_next = ZERO_W;
      end
      gate_next = (state_next == ST_GATE)
                  || (state_next == ST_STOP_WAIT);
      recip_next = (xm_eff == XM_AVG) && !ctrl_reg[HIRES_BIT];
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= ST_IDLE;
         tmr_reg <= ZERO_W;
         ev_reg <= ZERO_W;
         ticks_reg <= ZERO_W;
         ho_cnt_reg <= ZERO_W;
         gate_reg <= 1'b0;
         recip_reg <= 1'b0;
      end else if (ce_i) begin
         state_reg <= state_next;
         tmr_reg <= tmr_next;
         ev_reg <= ev_next;
         ticks_reg <= ticks_next;
         ho_cnt_reg <= ho_cnt_next;
         gate_reg <= gate_next;
         recip_reg <= recip_next;
      end
   end

   assign wb_dat_o = dat_reg;
   assign wb_ack_o = ack_reg;
   assign gate_open_o = gate_reg;
   assign reciprocal_o = recip_reg;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i || !ce_i);

   sequence s_held_reset;
      ext_reset_i [*2];
   endsequence

   AST_EXT_RESET_IDLE: assert property (
      s_held_reset |-> state_reg == ST_IDLE && !gate_reg)
      else $error("measurement not held idle during external reset");

   AST_EXT_RESET_KEEPS: assert property (
      ext_reset_i && !(wb_i.cyc && wb_i.stb) |=> ctrl_reg == $past(ctrl_reg))
      else $error("external reset disturbed the settings");

   AST_NO_GATE_AFTER_RESET: assert property (
      ext_reset_i |=> !gate_open_o ##1 !gate_open_o)
      else $error("gate opened too soon after external reset");

   AST_RECIP: assert property (
      xm_eff == XM_AVG && !ctrl_reg[HIRES_BIT] |=> reciprocal_o)
      else $error("averaging on low-res model not reciprocal");

   AST_HOLDOFF_STOP: assert property (
      state_reg == ST_GATE && time_fn && ho_block && !ext_reset_i
      |=> state_reg == ST_GATE)
      else $error("stop accepted during hold-off");

   AST_FILTER: assert property (
      state_reg == ST_GATE && !time_fn && ho_block && !ext_reset_i
      |=> ev_reg == $past(ev_reg))
      else $error("trigger counted during hold-off");

   AST_TID: assert property (
      state_reg == ST_GATE && tid_block && !ext_reset_i
      |=> state_reg == ST_GATE)
      else $error("stop accepted inside interval delay");

   AST_TID_EXCL: assert property (
      tid_eff |-> !ho_en && ctrl_reg[SINGLE_BIT] && time_fn)
      else $error("interval delay active in illegal combination");

   AST_GATE_OUT: assert property (
      state_reg == ST_STOP_WAIT |-> gate_open_o)
      else $error("gate monitor low during sync time");

   AST_ARM: assert property (
      state_reg == ST_ARM_WAIT && ctl_act && !ext_reset_i
      |=> state_reg == ST_ARM_WAIT)
      else $error("armed measurement started while control active");

   AST_GATE_START: assert property (
      state_reg == ST_START_WAIT && xm_eff == XM_GATE && !ctl_act
      |=> state_reg != ST_GATE)
      else $error("external gate started without gate signal");

   AST_REJECT: assert property (
      xm_sel == XM_GATE && fn != FN_FREQ && fn != FN_PERIOD
      |-> xm_eff == XM_OFF)
      else $error("conflicting control mode not rejected");

   AST_HO_TIMER: assert property (
      state_reg == ST_START_WAIT && start_ok && !ext_reset_i
      |=> ho_cnt_reg == ZERO_W && state_reg == ST_GATE)
      else $error("hold-off timer not restarted at start trigger");

   AST_ACK: assert property (
      wb_i.cyc && wb_i.stb && !ack_reg |=> ack_reg ##1 !ack_reg)
      else $error("bus answer not a single-cycle acknowledge");

endmodule : gho_gate_ctrl

// >>> gho_src.sv
// Purpose: Model of the signal source and the rear control generator.
// Assumes: Trigger lines idle low; pulses last one clock.
// Notes: The testbench calls the tasks; every change follows an edge.
`timescale 1ns/1ps
module gho_src (
   input wire logic clk_i,
   output logic trig_a_o,
   output logic trig_b_o,
   output logic ctrl_o
);
   initial begin
      trig_a_o = 1'b0;
      trig_b_o = 1'b0;
      ctrl_o = 1'b0;
   end
   task automatic pulse(input logic b);
      @(posedge clk_i);
      if (b) trig_b_o <= 1'b1;
      else trig_a_o <= 1'b1;
      @(posedge clk_i);
      trig_a_o <= 1'b0;
      trig_b_o <= 1'b0;
   endtask : pulse
   task automatic set_ctrl(input logic v);
      @(posedge clk_i);
      ctrl_o <= v;
   endtask : set_ctrl
   // Twenty input cycles, the window rising after ten, well before the end.
   task automatic burst();
      for (int i = 0; i < 20; i++) begin
         if (i == 10) ctrl_o <= 1'b1;
         pulse(1'b0);
      end
   endtask : burst
endmodule : gho_src

// >>> testbench.sv
// Purpose: Self-checking bench for the gate and hold-off control.
// Assumes: Classic Wishbone with a one-cycle answer.
// Notes: Short measuring and hold-off times are written over the bus.
`timescale 1ns/1ps
module testbench;
   import gho_pkg::*;
   localparam logic [31:0] RUN = 32'h0000_0400;
   localparam logic [31:0] HO = 32'h0000_0080;
   localparam logic [31:0] TID = 32'h0000_0100;
   localparam logic [31:0] SGL = 32'h0000_0200;
   localparam logic [31:0] HIR = 32'h0000_0800;
   localparam logic [31:0] SLP = 32'h0000_0040;
   localparam logic [31:0] XARM = 32'h0000_0010;
   localparam logic [31:0] XGATE = 32'h0000_0020;
   localparam logic [31:0] XAVG = 32'h0000_0030;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ext_rst = 1'b0;
   logic ce = 1'b1;
   logic [3:0] sel_v = 4'hf;
   gho_wb_req_t wb_i = '0;
   logic [DW-1:0] wb_dat_o;
   logic wb_ack_o, gate_open_o, reciprocal_o, trig_a, trig_b, ctrl;
   logic [31:0] q;
   logic [2:0] tf [3] = '{FN_INTERVAL, FN_WIDTH, FN_EDGE};
   logic [2:0] cf [4] = '{FN_FREQ, FN_PERIOD, FN_RATIO, FN_TOTAL};
   int n_errors = 0;
   int n_tests = 0;
   always #4 clk_i = ~clk_i;
   gho_gate_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
      .wb_i(wb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .trig_a_i(trig_a), .trig_b_i(trig_b), .rear_control_i(ctrl),
      .ext_reset_i(ext_rst), .gate_open_o(gate_open_o),
      .reciprocal_o(reciprocal_o));
   gho_src u_src (.clk_i(clk_i), .trig_a_o(trig_a), .trig_b_o(trig_b),
      .ctrl_o(ctrl));
   task automatic summarize();
      $display("Checks %0d, errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : summarize
   task automatic chk(input string s, input logic [31:0] got,
                      input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", s, exp, got);
      end
   endtask : chk
   task automatic tmo();
      chk("wait", 32'h0000_0000, 32'h0000_0001);
      summarize();
   endtask : tmo
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      int n;
      @(posedge clk_i);
      wb_i <= '{1'b1, 1'b1, w, sel_v, a, d};
      for (n = 0; n < 20; n++) begin
         @(posedge clk_i);
         if (wb_ack_o === 1'b1) break;
      end
      if (n == 20) tmo();
      q = wb_dat_o;
      wb_i <= '0;
   endtask : wb
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, '0);
      chk("read", q, e);
   endtask : rc
   task automatic st(input int b, input logic e);
      wb(1'b0, ADR_STATUS, '0);
      chk("status", 32'(q[b]), 32'(e));
   endtask : st
   task automatic gw(input logic v);
      int n;
      for (n = 0; n < 40; n++) begin
         @(posedge clk_i);
         if (gate_open_o === v) break;
      end
      if (n == 40) tmo();
   endtask : gw
   task automatic gs(input logic v);
      repeat (3) @(posedge clk_i);
      chk("gate", 32'(gate_open_o), 32'(v));
   endtask : gs
   task automatic idle();
      wb(1'b1, ADR_CTRL, '0);
      ext_rst <= 1'b1;
      repeat (2) @(posedge clk_i);
      ext_rst <= 1'b0;
   endtask : idle
   task automatic t_regs();
      rc(ADR_CTRL, '0);
      rc(ADR_HOLDOFF, '0);
      rc(ADR_MEASTIME, 32'h0001_E848);
      // Only the lowest byte lane is enabled for this write.
      sel_v = 4'h1;
      wb(1'b1, ADR_HOLDOFF, 32'hFFFF_FF5A);
      sel_v = 4'hf;
      rc(ADR_HOLDOFF, 32'h0000_005A);
      wb(1'b1, 8'h18, 32'hFFFF_FFFF);
      rc(8'h18, '0);
      wb(1'b1, ADR_TICKS, 32'hFFFF_FFFF);
      rc(ADR_TICKS, '0);
   endtask : t_regs
   task automatic t_hold();
      wb(1'b1, ADR_HOLDOFF, 32'h0000_0014);
      wb(1'b1, ADR_MEASTIME, 32'h0000_0100);
      foreach (cf[i]) begin
         wb(1'b1, ADR_CTRL, RUN | HO | 32'(cf[i]));
         u_src.pulse(1'b0);
         gw(1'b1);
         st(ST_HOBLK_BIT, 1'b1);
         u_src.pulse(1'b0);
         rc(ADR_EVENTS, 32'h0000_0000);
         repeat (25) @(posedge clk_i);
         st(ST_HOBLK_BIT, 1'b0);
         u_src.pulse(1'b0);
         rc(ADR_EVENTS, 32'h0000_0001);
         st(ST_HOBLK_BIT, 1'b1);
         idle();
      end
   endtask : t_hold
   task automatic t_time(input logic [31:0] m, input int w);
      foreach (tf[i]) begin
         wb(1'b1, ADR_CTRL, RUN | m | 32'(tf[i]));
         if (m[8]) st(ST_TID_BIT, 1'b1);
         u_src.pulse(1'b0);
         gw(1'b1);
         u_src.pulse(1'b1);
         gs(1'b1);
         repeat (w) @(posedge clk_i);
         u_src.pulse(1'b1);
         gs(1'b0);
         idle();
      end
   endtask : t_time
   task automatic t_excl();
      foreach (tf[i]) begin
         wb(1'b1, ADR_CTRL, RUN | TID | HO | SGL | 32'(tf[i]));
         st(ST_TID_BIT, 1'b0);
      end
      wb(1'b1, ADR_CTRL, RUN | TID | SGL);
      st(ST_TID_BIT, 1'b0);
      wb(1'b1, ADR_CTRL, RUN | TID | 32'(FN_WIDTH));
      st(ST_TID_BIT, 1'b0);
      idle();
   endtask : t_excl
   task automatic t_ext();
      wb(1'b1, ADR_CTRL, RUN);
      u_src.pulse(1'b0);
      gw(1'b1);
      repeat (30) @(posedge clk_i);
      gs(1'b1);
      ext_rst <= 1'b1;
      gs(1'b0);
      u_src.pulse(1'b0);
      gs(1'b0);
      rc(ADR_CTRL, RUN);
      ext_rst <= 1'b0;
      u_src.pulse(1'b0);
      gs(1'b1);
      idle();
   endtask : t_ext
   // A stop pulse seen while the clock enable is low must not close the gate.
   task automatic t_ce();
      wb(1'b1, ADR_CTRL, RUN | 32'(FN_INTERVAL));
      u_src.pulse(1'b0);
      gw(1'b1);
      ce <= 1'b0;
      u_src.pulse(1'b1);
      gs(1'b1);
      ce <= 1'b1;
      u_src.pulse(1'b1);
      gs(1'b0);
      idle();
   endtask : t_ce
   task automatic t_arm();
      for (int s = 0; s < 2; s++) begin
         u_src.set_ctrl(s == 0);
         wb(1'b1, ADR_CTRL, RUN | XARM | (s == 1 ? SLP : '0));
         u_src.pulse(1'b0);
         gs(1'b0);
         u_src.set_ctrl(s == 1);
         @(posedge clk_i);
         u_src.pulse(1'b0);
         gs(1'b1);
         idle();
      end
      u_src.set_ctrl(1'b0);
   endtask : t_arm
   task automatic t_xm();
      wb(1'b1, ADR_CTRL, RUN | XGATE);
      u_src.pulse(1'b0);
      gs(1'b0);
      u_src.set_ctrl(1'b1);
      u_src.pulse(1'b0);
      gs(1'b1);
      u_src.set_ctrl(1'b0);
      gs(1'b1);
      u_src.pulse(1'b0);
      gs(1'b0);
      idle();
      wb(1'b1, ADR_CTRL, RUN | XGATE | 32'(FN_RATIO));
      st(ST_XREJ_BIT, 1'b1);
      u_src.pulse(1'b0);
      gs(1'b1);
      idle();
      wb(1'b1, ADR_CTRL, XAVG | 32'(FN_PERIOD));
      st(ST_XREJ_BIT, 1'b1);
      wb(1'b1, ADR_CTRL, XARM | 32'(FN_TOTAL));
      st(ST_XREJ_BIT, 1'b1);
      wb(1'b1, ADR_CTRL, RUN | XAVG);
      // With the sample window inactive no clock may be accumulated.
      u_src.pulse(1'b0);
      rc(ADR_TICKS, '0);
      u_src.burst();
      chk("recip", 32'(reciprocal_o), 32'h0000_0001);
      wb(1'b1, ADR_CTRL, RUN | XAVG | HIR);
      repeat (2) @(posedge clk_i);
      chk("recip", 32'(reciprocal_o), 32'h0000_0000);
      u_src.set_ctrl(1'b0);
      idle();
   endtask : t_xm
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_hold();
      wb(1'b1, ADR_HOLDOFF, 32'h0000_000C);
      t_time(HO, 12);
      wb(1'b1, ADR_MEASTIME, 32'h0000_0010);
      t_time(TID | SGL, 16);
      t_excl();
      t_ext();
      t_ce();
      t_arm();
      t_xm();
      summarize();
   end
endmodule : testbench
